// >>> rtl/sample_port_pkg.sv
// sample_port_pkg: widths, codes and timing constants for the converter output port
// assumes: one 200 MHz clock, synchronous active-high reset
package sample_port_pkg;
    // ****************************************************************
    // word format
    // ****************************************************************
    localparam int unsigned WORD_W      = 12;               // result width
    localparam logic [11:0] OFFSET_ZERO = 12'h800;          // offset binary midscale
    localparam logic [11:0] SIGN_FLIP   = 12'h800;          // two's complement to offset
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLOCK_MHZ      = 200;           // system clock rate
    localparam int unsigned MIN_RATE_MSPS  = 40;            // least sustained sample rate
    // longest sample period rounds down to whole clocks
    localparam int unsigned SAMPLE_CYCLES  = CLOCK_MHZ / MIN_RATE_MSPS;
    localparam int unsigned PIPE_LATENCY   = 6;             // sample strobes from sample edge to word
    localparam int unsigned WAKE_CYCLES    = 8;             // invalid words after power-down
    localparam int unsigned BUF_DEPTH      = 2;             // output buffer entries
    localparam int unsigned CNT_W          = 4;             // width of small counters
    localparam logic [3:0]  CNT_ZERO       = 4'h0;          // counter reset value
    localparam logic [3:0]  CNT_ONE        = 4'h1;          // counter step
endpackage

// >>> rtl/word_buffer.sv
// word_buffer: two-entry buffer with valid/ready on both sides
// assumes: same clock as the converter core, synchronous reset
`timescale 1ns/1ps
module word_buffer (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // fill side
    input  wire logic        in_valid_i,
    output logic             in_ready_o,
    input  wire logic [11:0] in_data_i,
    // drain side
    output logic             out_valid_o,
    input  wire logic        out_ready_i,
    output logic [11:0]      out_data_o
);
    // ****************************************************************
    // storage
    // ****************************************************************
    logic [11:0] slot [0:1];    // entries
    logic        wr_ptr;        // next slot to write
    logic        rd_ptr;        // next slot to read
    logic [1:0]  fill;          // entries held
    logic        push;          // accepted write
    logic        pop;           // accepted read

    // ready only while a slot is free, so the source really stalls
    assign in_ready_o  = (fill != 2'h2);
    assign out_valid_o = (fill != 2'h0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // write port
    always_ff @(posedge clock_i) begin
        if (push) begin
            slot[wr_ptr] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill   <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end

    // read data from a register: holds the head word
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_data_o <= 12'h000;
        end else if (pop && fill == 2'h2) begin
            out_data_o <= slot[~rd_ptr];   // next entry becomes head
        end else if (push && (fill == 2'h0 || (pop && fill == 2'h1))) begin
            out_data_o <= in_data_i;       // word lands directly at head
        end
    end
endmodule // word_buffer

// >>> rtl/sample_port.sv
// sample_port: control and output side of a 12-bit pipelined converter
// assumes: analog core delivers a two's complement code each sample strobe;
// output enable and sleep request arrive from pins and are synchronised here
// limitation: a full buffer stops sampling, so the rate holds only while drained
// the analog front end and reference sit outside this block
// Behaviour
// - sample only on rising clock edges
// - drive bus when enable low, else release
// - sleep request high enters power-down
// - sleep request low means active conversion
// - results are 12-bit offset binary words
// - bit zero LSB, bit eleven MSB
// - at least 40 Msps, one word per sample
`timescale 1ns/1ps
module sample_port (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // analog core code, same clock domain
    input  wire logic [11:0] core_code_i,
    // pins from capture logic
    input  wire logic        out_enable_n_i,
    input  wire logic        sleep_request_i,
    // three-state data bus
    output logic [11:0]      sample_word_bus_o,
    output logic [11:0]      sample_word_bus_oe_o,
    // sample stream toward capture side
    output logic             word_valid_o,
    input  wire logic        word_ready_i,
    // status
    output logic             sample_strobe_o,
    output logic             powered_down_o
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic oe_n_meta;        // first stage, read only by second stage
    logic oe_n_sync;        // synchronised output enable
    logic sleep_meta;       // first stage
    logic sleep_sync;       // synchronised sleep request

    // two flops per pin; reset idles the bus released and awake
    // nothing but the second stage reads the first, which may be metastable
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            oe_n_meta  <= 1'b1;
            oe_n_sync  <= 1'b1;
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            oe_n_meta  <= out_enable_n_i;
            oe_n_sync  <= oe_n_meta;
            sleep_meta <= sleep_request_i;
            sleep_sync <= sleep_meta;
        end
    end

    // ****************************************************************
    // sample control, shared by the mode machine and the divider
    // ****************************************************************
    logic [sample_port_pkg::CNT_W-1:0] div_cnt;   // clocks within a sample period
    logic                              strobe;    // one-cycle sample enable
    logic                              stalled;   // buffer full, hold the sample

    // ****************************************************************
    // mode machine
    // ****************************************************************
    typedef enum logic [1:0] {ACTIVE, ASLEEP, WAKING} mode_t;
    mode_t                        mode;       // current mode
    logic [sample_port_pkg::CNT_W-1:0] wake_cnt;   // words discarded after wake

    // sleep wins at once; waking discards the first words out of the pipe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode     <= ACTIVE;
            wake_cnt <= sample_port_pkg::CNT_ZERO;
        end else begin
            case (mode)
                // awake: a held request puts the core to sleep
                ACTIVE: begin
                    if (sleep_sync) begin
                        mode <= ASLEEP;
                    end
                end
                // asleep: a released request starts the wake-up discard
                ASLEEP: begin
                    if (!sleep_sync) begin
                        mode     <= WAKING;
                        wake_cnt <= sample_port_pkg::CNT_ZERO;
                    end
                end
                // waking: the first words out of the pipe are discarded
                // a new request while waking goes straight back to sleep
                WAKING: begin
                    if (sleep_sync) begin
                        mode <= ASLEEP;
                    end else if (strobe) begin
                        if (wake_cnt == 4'(sample_port_pkg::WAKE_CYCLES - 1)) begin
                            mode <= ACTIVE;
                        end
                        wake_cnt <= wake_cnt + sample_port_pkg::CNT_ONE;
                    end
                end
                default: begin
                    mode <= ACTIVE;
                end
            endcase
        end
    end

    // status shows sleep only once the machine has really gone to sleep
    assign powered_down_o = (mode == ASLEEP);

    // ****************************************************************
    // sample rate divider
    // ****************************************************************
    // while the buffer is full the count climbs to its last value and holds there

    // strobe once per period on the rising edge; stops while asleep
    // trade-off: a stalled divider lowers the rate but never drops a word
    assign strobe = (mode != ASLEEP) && !stalled &&
                    (div_cnt == 4'(sample_port_pkg::SAMPLE_CYCLES - 1));

    always_ff @(posedge clock_i) begin
        if (rst_i || mode == ASLEEP) begin
            div_cnt <= sample_port_pkg::CNT_ZERO;
        end else if (div_cnt != 4'(sample_port_pkg::SAMPLE_CYCLES - 1)) begin
            div_cnt <= div_cnt + sample_port_pkg::CNT_ONE;
        end else if (!stalled) begin
            div_cnt <= sample_port_pkg::CNT_ZERO;
        end
    end

    // the strobe is also offered as a status output
    assign sample_strobe_o = strobe;

    // ****************************************************************
    // coding and latency pipe
    // ****************************************************************
    logic [11:0] pipe_word  [0:sample_port_pkg::PIPE_LATENCY-1]; // words in flight
    logic        pipe_valid [0:sample_port_pkg::PIPE_LATENCY-1]; // valid flags
    logic        fill_valid;      // word leaving the pipe is usable
    logic        fill_ready;      // buffer can accept

    // pipe advances on each strobe; invalid during wake-up discard
    generate
        for (genvar s = 0; s < sample_port_pkg::PIPE_LATENCY; s++) begin : g_pipe
            if (s == 0) begin : g_head
                // first stage codes the core sample as it is taken
                always_ff @(posedge clock_i) begin
                    if (rst_i || mode == ASLEEP) begin
                        pipe_word[s]  <= sample_port_pkg::OFFSET_ZERO;
                        pipe_valid[s] <= 1'b0;
                    end else if (strobe) begin
                        // offset binary: flip the sign bit of the core code
                        pipe_word[s]  <= core_code_i ^ sample_port_pkg::SIGN_FLIP;
                        // words taken while waking are marked unusable
                        pipe_valid[s] <= (mode == ACTIVE);
                    end
                end
            end else begin : g_tail
                // later stages only shift; no stage index falls below zero
                always_ff @(posedge clock_i) begin
                    if (rst_i || mode == ASLEEP) begin
                        pipe_word[s]  <= sample_port_pkg::OFFSET_ZERO;
                        pipe_valid[s] <= 1'b0;
                    end else if (strobe) begin
                        pipe_word[s]  <= pipe_word[s-1];
                        pipe_valid[s] <= pipe_valid[s-1];
                    end
                end
            end
        end
    endgenerate

    // push the last stage once, in the strobe that retires it
    // a word that was invalid on entry never reaches the buffer
    assign fill_valid = strobe && pipe_valid[sample_port_pkg::PIPE_LATENCY-1];
    // a full buffer holds the divider so no word is lost
    assign stalled    = !fill_ready;

    // ****************************************************************
    // output buffer
    // ****************************************************************
    // two entries ride out a stall of the receiver without a lost word
    logic [11:0] head_word;   // registered head of buffer

    word_buffer u_buffer (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (fill_valid),
        .in_ready_o  (fill_ready),
        .in_data_i   (pipe_word[sample_port_pkg::PIPE_LATENCY-1]),
        .out_valid_o (word_valid_o),
        .out_ready_i (word_ready_i),
        .out_data_o  (head_word)
    );

    // ****************************************************************
    // three-state bus
    // ****************************************************************
    // bit i of the word sits on bus bit i: bit 0 LSB, bit 11 MSB
    // the bus trails the buffer head by one clock; capture allows for it
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sample_word_bus_o <= 12'h000;
        end else begin
            sample_word_bus_o <= head_word;
        end
    end

    // enables follow the synchronised enable pin; all bits together
    // driving and releasing both take three edges from the pin
    // the pad turns these enables into three-state drivers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sample_word_bus_oe_o <= 12'h000;
        end else begin
            sample_word_bus_oe_o <= {12{~oe_n_sync}};
        end
    end
endmodule // sample_port

// >>> tb/sample_port_monitor.sv
// sample_port_monitor: port assertions for the converter output port
// assumes: bound to sample_port, one clock domain, synchronous reset
`timescale 1ns/1ps
module sample_port_monitor (
    // watched ports
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic [11:0] core_code_i,
    input wire logic        out_enable_n_i,
    input wire logic        sleep_request_i,
    input wire logic [11:0] sample_word_bus_o,
    input wire logic [11:0] sample_word_bus_oe_o,
    input wire logic        word_valid_o,
    input wire logic        word_ready_i,
    input wire logic        sample_strobe_o,
    input wire logic        powered_down_o
);
    // ****************************************
    // checks: five clocks cover the three-edge pin path with margin
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence stall_s; word_valid_o && !word_ready_i; endsequence
    strobe_gap_a: assert property (sample_strobe_o |=> !sample_strobe_o [*4])
        else $error("strobes closer than five clocks");
    oe_drive_a: assert property (!out_enable_n_i [*5] |-> &sample_word_bus_oe_o)
        else $error("bus not driven while enabled");
    oe_release_a: assert property (out_enable_n_i [*5] |-> !(|sample_word_bus_oe_o))
        else $error("bus not released");
    oe_whole_a: assert property (sample_word_bus_oe_o inside {12'h000, 12'hFFF})
        else $error("bus bits enabled apart");
    sleep_enter_a: assert property (sleep_request_i [*5] |-> powered_down_o)
        else $error("sleep not entered");
    sleep_leave_a: assert property (!sleep_request_i [*5] |-> !powered_down_o)
        else $error("sleep not left");
    asleep_quiet_a: assert property (powered_down_o ##1 powered_down_o |-> !sample_strobe_o)
        else $error("strobe while asleep");
    wake_quiet_a: assert property ($fell(powered_down_o) |-> !sample_strobe_o [*4])
        else $error("strobe too soon after wake");
    valid_hold_a: assert property (stall_s |=> word_valid_o)
        else $error("word dropped under stall");
    head_hold_a: assert property (stall_s ##1 stall_s |=> $stable(sample_word_bus_o))
        else $error("bus word moved under stall");
endmodule // sample_port_monitor
bind sample_port sample_port_monitor monitor_u (.clock_i, .rst_i, .core_code_i, .out_enable_n_i,
    .sleep_request_i, .sample_word_bus_o, .sample_word_bus_oe_o, .word_valid_o, .word_ready_i,
    .sample_strobe_o, .powered_down_o);

// >>> tb/capture_model.sv
// capture_model: downstream logic reading words off the sample bus
// assumes: bench resolves the bus wire, one word popped per handshake
`timescale 1ns/1ps
module capture_model (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // bus and stream
    input  wire logic [11:0] bus_wire_i,
    input  wire logic        word_valid_i,
    input  wire logic        stall_i,
    output logic             word_ready_o
);
    logic [11:0] got [$];   // words taken, in arrival order
    logic        seen;      // valid seen at the last edge
    // ****************************************
    // capture: bus trails the head by a clock, so wait one edge first
    // ****************************************
    always @(posedge clock_i) begin
        if (rst_i || word_ready_o) begin
            word_ready_o <= 1'b0;
            seen         <= 1'b0;
        end else if (seen && word_valid_i && !stall_i) begin
            got.push_back(bus_wire_i);
            word_ready_o <= 1'b1;
            seen         <= 1'b0;
        end else begin
            seen <= word_valid_i;
        end
    end
endmodule // capture_model

// >>> tb/test_adc_sample_output_port.sv
// test_adc_sample_output_port: self-checking bench for sample_port
// assumes: capture_model as far side, core codes made here per strobe
`timescale 1ns/1ps
module test_adc_sample_output_port;
    logic        clock_i = 1'b0, rst_i = 1'b1, out_enable_n_i = 1'b1;
    logic        sleep_request_i = 1'b0, stall = 1'b0;
    logic [11:0] core_code_i = 12'h000;  // bit 11 copies bit 0, so no code is a flipped code
    logic [10:0] code_n = 11'h001;
    logic [11:0] bus, oe, sent [$];
    wire  [11:0] bus_wire = (bus & oe) | (~bus & ~oe);  // released bits show the inverted bus bit
    logic        valid, ready, strobe, asleep;
    int          mismatches = 0, checked = 0, strobes = 0;
    always #2.5 clock_i = ~clock_i;
    sample_port dut_u (.clock_i, .rst_i, .core_code_i, .out_enable_n_i, .sleep_request_i,
        .sample_word_bus_o(bus), .sample_word_bus_oe_o(oe), .word_valid_o(valid),
        .word_ready_i(ready), .sample_strobe_o(strobe), .powered_down_o(asleep));
    capture_model partner_u (.clock_i, .rst_i, .bus_wire_i(bus_wire), .word_valid_i(valid),
        .stall_i(stall), .word_ready_o(ready));
    // ****************************************
    // core stand-in: record each sampled code, then move to the next
    // ****************************************
    always @(posedge clock_i) begin
        if (strobe && !rst_i) begin
            sent.push_back(core_code_i);
            strobes     <= strobes + 1;
            core_code_i <= {code_n[0], code_n};
            code_n      <= code_n + 11'h001;
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // every word taken must be an offset code, in order, none missing
    task automatic verify_words();
        int idx = -1;
        check(12'(partner_u.got.size() > 4), 12'h001);
        foreach (sent[k]) if ((sent[k] ^ 12'h800) === partner_u.got[0]) idx = k;
        check(12'(idx >= 0), 12'h001);
        foreach (partner_u.got[i]) if (idx >= 0 && idx + i < sent.size())
            check(partner_u.got[i], sent[idx + i] ^ 12'h800);
    endtask
    task automatic test_enable();
        out_enable_n_i <= 1'b1;
        tick(8);
        check(oe, 12'h000);
        out_enable_n_i <= 1'b0;
        tick(8);
        check(oe, 12'hFFF);
        $display("test_enable done");
    endtask
    task automatic test_stream();
        int s0;
        tick(100);
        s0 = strobes;
        tick(200);
        check(12'(strobes - s0), 12'(200 / sample_port_pkg::SAMPLE_CYCLES));
        verify_words();
        $display("test_stream done");
    endtask
    task automatic test_stall();
        stall <= 1'b1;
        tick(150);
        check(12'(valid), 12'h001);
        stall <= 1'b0;
        tick(100);
        verify_words();
        $display("test_stall done");
    endtask
    task automatic test_sleep();
        int s0;
        sleep_request_i <= 1'b1;
        tick(10);
        check(12'(asleep), 12'h001);
        s0 = strobes;
        tick(50);
        check(12'(strobes - s0), 12'h000);
        partner_u.got.delete();
        sent.delete();
        sleep_request_i <= 1'b0;
        tick(10);
        check(12'(asleep), 12'h000);
        tick(250);
        verify_words();
        $display("test_sleep done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog: tests need about 900 clocks
    initial begin
        #50000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        tick(20);
        rst_i <= 1'b0;
        test_enable();
        test_stream();
        test_stall();
        test_sleep();
        tally_and_finish();
    end
endmodule // test_adc_sample_output_port
